// ==== src/fpx_defs.svh ====
// Purpose: Offsets, field positions, codes and reset values of the exception unit
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef FPX_DEFS_SVH
`define FPX_DEFS_SVH
`define FPX_OFF_CTRL 5'h00
`define FPX_OFF_STAT 5'h04
`define FPX_OFF_TAG 5'h08
`define FPX_OFF_IMASK 5'h0c
`define FPX_OFF_CMD 5'h10
`define FPX_CTRL_RST 16'h037f
`define FPX_CTRL_WMASK 16'h1f3f
`define FPX_STAT_W1C 16'h007f
`define FPX_STAT_CMASK 16'h4700
`define FPX_IMASK_WMASK 7'h7f
`define FPX_CMD_INIT 0
`define CW_IM 0
`define CW_DM 1
`define CW_OM 3
`define CW_UM 4
`define CW_PC_LO 8
`define CW_RC_LO 10
`define CW_IC 12
`define SW_IE 0
`define SW_DE 1
`define SW_OE 3
`define SW_UE 4
`define SW_PE 5
`define SW_SF 6
`define SW_ES 7
`define SW_C1 9
`define TAG_VALID 2'h0
`define TAG_ZERO 2'h1
`define TAG_SPECIAL 2'h2
`define TAG_EMPTY 2'h3
`define RC_CHOP 2'h3
`define PC_EXT 2'h3
`define EXP_MAX 15'h7fff
`define NUM_REGS 8
`endif

// ==== src/fpx_pkg.sv ====
// Purpose: Types shared by the exception unit
// Assumes: Nothing
// Notes: Types only
package fpx_pkg;
	typedef enum logic [2:0]
	{
		OPK_ARITH,
		OPK_COMPARE,
		OPK_INT_STORE,
		OPK_BCD_STORE,
		OPK_TRANSC,
		OPK_EXTRACT,
		OPK_MOVE
	} op_kind_e;
	typedef logic [79:0] ext_t;
endpackage

// ==== src/operand_class_if.sv ====
// Purpose: Carries one register value and its classification
// Assumes: One classifier per instance
// Notes: None
`timescale 1ns/1ps
`default_nettype none
interface operand_class_if;
	fpx_pkg::ext_t value;
	logic [1:0] tag;
	logic snan;
	logic qnan;
	logic denorm;
	logic unsup;
	modport classify(input value, output tag, snan, qnan, denorm, unsup);
	modport user(output value, input tag, snan, qnan, denorm, unsup);
endinterface
`default_nettype wire

// ==== src/operand_classifier.sv ====
// Purpose: Classifies one extended-precision value from its bits
// Assumes: Sign 79, exponent 78:64, integer bit 63, fraction 62:0
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
`include "fpx_defs.svh"
module operand_classifier
(
	operand_class_if.classify cls
);
	logic [14:0] ex;
	logic jbit;
	logic [62:0] frac;
	assign ex = cls.value[78:64];
	assign jbit = cls.value[63];
	assign frac = cls.value[62:0];
	always_comb
	begin
		cls.tag = `TAG_VALID;
		cls.snan = 1'b0;
		cls.qnan = 1'b0;
		cls.denorm = 1'b0;
		cls.unsup = 1'b0;
		if (ex == 15'h0000)
		begin
			if (!jbit && frac == 63'h0)
				cls.tag = `TAG_ZERO;
			else
			begin
				cls.tag = `TAG_SPECIAL;
				cls.denorm = 1'b1;
			end
		end
		else if (!jbit)
		begin
			// Unnormal, pseudo-zero, pseudo-NaN, pseudo-infinity
			cls.tag = `TAG_SPECIAL; // RULE5
			cls.unsup = 1'b1;
		end
		else if (ex == `EXP_MAX)
		begin
			cls.tag = `TAG_SPECIAL;
			if (frac != 63'h0)
			begin
				cls.qnan = frac[62]; // RULE6
				cls.snan = !frac[62];
			end
		end
	end
endmodule
`default_nettype wire

// ==== src/fp_special_value_exception_unit.sv ====
// Purpose: Special-value, tag and exception handling of the floating-point unit
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Overview below
//
// Overview of operation
// RULE1 - Infinity-control bit is stored and read back but never affects behaviour.
// RULE2 - Tag load marks codes 00, 01, 10 non-empty and 11 empty only.
// RULE3 - Non-empty register operands are classified from contents, not loaded tags.
// RULE4 - Tag store computes each non-empty register's tag from its contents.
// RULE5 - Unsupported formats such as pseudo-zero and unnormal tag as special.
// RULE6 - Signaling and quiet NaNs are distinguished; produced NaNs are always quiet.
// RULE7 - Signaling NaN raises invalid; quiet NaN too for compare and integer/BCD stores.
// RULE8 - Pseudo or unnormal operands raise invalid; such values are never produced.
// RULE9 - Masked denormal exception normalizes denormal operands when possible.
// RULE10 - Denormal exception is also raised for transcendental and exponent-extract.
// RULE11 - Masked overflow rounding toward zero returns largest finite, not infinity.
// RULE12 - Unmasked overflow also sets the precision flag.
// RULE13 - Unmasked overflow to stack rounds by precision control or opcode precision.
// RULE14 - Masked underflow is flagged only when tiny and accuracy is lost.
// RULE15 - Unmasked underflow to stack adjusts exponent then rounds by PC or extended.
// RULE16 - Stack fault sets invalid bit 0 and bit 6; condition one shows direction.
// RULE17 - Condition bits 8, 9, 10, 14 clear on reset and initialize.
// RULE18 - Each raised exception stays in its sticky flag until software clears it.
`timescale 1ns/1ps
`default_nettype none
`include "fpx_defs.svh"
module fp_special_value_exception_unit
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [4:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic IRQ,
	input wire logic REG_WE,
	input wire logic [2:0] REG_IDX,
	input wire fpx_pkg::ext_t REG_VALUE,
	input wire logic OP_VALID,
	input wire fpx_pkg::op_kind_e OP_KIND,
	input wire logic [2:0] OP_REG,
	input wire logic RES_VALID,
	input wire logic RES_OVERFLOW,
	input wire logic RES_TINY,
	input wire logic RES_LOSS,
	input wire logic RES_INEXACT,
	input wire logic RES_STACK,
	input wire logic RES_PC_CTRL,
	input wire logic [1:0] RES_PREC,
	input wire logic STACK_FAULT,
	input wire logic STACK_OVER,
	output logic RESP_VALID,
	output logic RESP_INVALID,
	output logic RESP_NORMALIZE,
	output logic RESP_QUIET_NAN,
	output logic RESP_MAX_FINITE,
	output logic RESP_INFINITY,
	output logic RESP_ADJUST_EXP,
	output logic [1:0] RESP_ROUND_PREC
);
	// Register file and data registers
	logic [15:0] ctrl;
	logic [15:0] stat;
	logic [6:0] imask;
	logic [`NUM_REGS-1:0] empty;
	fpx_pkg::ext_t regs [`NUM_REGS];
	logic [15:0] next_ctrl;
	logic [15:0] next_stat;
	logic [6:0] next_imask;
	logic [`NUM_REGS-1:0] next_empty;
	fpx_pkg::ext_t next_regs [`NUM_REGS];
	logic [31:0] next_rdata;
	logic next_irq;

	// Response outputs
	logic next_resp_valid;
	logic next_resp_invalid;
	logic next_resp_normalize;
	logic next_resp_quiet_nan;
	logic next_resp_max_finite;
	logic next_resp_infinity;
	logic next_resp_adjust_exp;
	logic [1:0] next_resp_round_prec;

	// Per-register classification
	logic [1:0] tag_calc [`NUM_REGS];
	logic [`NUM_REGS-1:0] snan_all;
	logic [`NUM_REGS-1:0] qnan_all;
	logic [`NUM_REGS-1:0] den_all;
	logic [`NUM_REGS-1:0] unsup_all;
	logic [15:0] tag_word;

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_REGS; gi++)
		begin : g_cls
			operand_class_if cif();
			assign cif.value = regs[gi];
			operand_classifier u_cls
			(
				.cls(cif)
			);
			assign tag_calc[gi] = cif.tag;
			assign snan_all[gi] = cif.snan;
			assign qnan_all[gi] = cif.qnan;
			assign den_all[gi] = cif.denorm;
			assign unsup_all[gi] = cif.unsup;
			assign tag_word[2*gi+1:2*gi] = empty[gi] ? `TAG_EMPTY : tag_calc[gi]; // RULE4
		end
	endgenerate

	// Control word fields
	logic [1:0] pc;
	logic [1:0] rc;
	assign pc = ctrl[`CW_PC_LO+1:`CW_PC_LO];
	assign rc = ctrl[`CW_RC_LO+1:`CW_RC_LO];

	// Selected operand, classified from its contents
	logic op_snan;
	logic op_qnan;
	logic op_den;
	logic op_unsup;
	logic op_arith;
	logic op_strict;
	logic op_inv;
	logic op_dexc;
	assign op_snan = snan_all[OP_REG]; // RULE3
	assign op_qnan = qnan_all[OP_REG];
	assign op_den = den_all[OP_REG];
	assign op_unsup = unsup_all[OP_REG];
	assign op_arith = OP_VALID && OP_KIND != fpx_pkg::OPK_MOVE;
	assign op_strict = OP_KIND == fpx_pkg::OPK_COMPARE || OP_KIND == fpx_pkg::OPK_INT_STORE
		|| OP_KIND == fpx_pkg::OPK_BCD_STORE;
	assign op_inv = op_arith && (op_snan || (op_qnan && op_strict) || op_unsup); // RULE7 RULE8
	assign op_dexc = op_arith && op_den; // RULE10

	// Bus decode
	logic wr_ctrl;
	logic wr_stat;
	logic wr_tag;
	logic wr_imask;
	logic do_init;
	assign wr_ctrl = WR && ADDR == `FPX_OFF_CTRL;
	assign wr_stat = WR && ADDR == `FPX_OFF_STAT;
	assign wr_tag = WR && ADDR == `FPX_OFF_TAG;
	assign wr_imask = WR && ADDR == `FPX_OFF_IMASK;
	assign do_init = WR && ADDR == `FPX_OFF_CMD && WDATA[`FPX_CMD_INIT];

	// Events from operands, results and stack faults
	logic [15:0] set_bits;
	always_comb
	begin
		set_bits = 16'h0000;
		next_resp_valid = OP_VALID || RES_VALID;
		next_resp_invalid = op_inv;
		next_resp_normalize = op_dexc && ctrl[`CW_DM]; // RULE9
		next_resp_quiet_nan = op_arith && (op_snan || op_qnan || (op_inv && ctrl[`CW_IM])); // RULE6
		next_resp_max_finite = 1'b0;
		next_resp_infinity = 1'b0;
		next_resp_adjust_exp = 1'b0;
		next_resp_round_prec = pc;
		if (op_inv)
		begin
			set_bits[`SW_IE] = 1'b1; // RULE18
		end
		if (op_dexc)
		begin
			set_bits[`SW_DE] = 1'b1; // RULE18
		end
		if (RES_VALID && RES_OVERFLOW)
		begin
			set_bits[`SW_OE] = 1'b1;
			set_bits[`SW_PE] = 1'b1;
			if (ctrl[`CW_OM])
			begin
				// Infinity control is ignored: always affine
				if (rc == `RC_CHOP)
					next_resp_max_finite = 1'b1; // RULE11
				else
					next_resp_infinity = 1'b1; // RULE1
			end
			else if (RES_STACK)
			begin
				next_resp_round_prec = RES_PC_CTRL ? pc : RES_PREC; // RULE13
			end
			if (!ctrl[`CW_OM])
			begin
				set_bits[`SW_PE] = 1'b1; // RULE12
			end
		end
		else if (RES_VALID && RES_TINY)
		begin
			if (ctrl[`CW_UM])
			begin
				if (RES_LOSS)
				begin
					set_bits[`SW_UE] = 1'b1; // RULE14
					set_bits[`SW_PE] = 1'b1;
				end
			end
			else
			begin
				set_bits[`SW_UE] = 1'b1;
				if (RES_STACK)
				begin
					next_resp_adjust_exp = 1'b1; // RULE15
					next_resp_round_prec = RES_PC_CTRL ? pc : `PC_EXT; // RULE15
				end
			end
		end
		if (RES_VALID && RES_INEXACT)
		begin
			set_bits[`SW_PE] = 1'b1;
		end
		if (STACK_FAULT)
		begin
			set_bits[`SW_IE] = 1'b1; // RULE16
			set_bits[`SW_SF] = 1'b1; // RULE16
		end
	end

	// Register file next state
	always_comb
	begin
		next_ctrl = ctrl;
		next_stat = stat;
		next_imask = imask;
		next_empty = empty;
		for (int i = 0; i < `NUM_REGS; i++)
		begin
			next_regs[i] = regs[i];
		end
		if (wr_ctrl)
		begin
			// Infinity-control bit kept writable
			next_ctrl = WDATA[15:0] & `FPX_CTRL_WMASK; // RULE1
		end
		if (wr_stat)
		begin
			next_stat = (stat & ~(WDATA[15:0] & `FPX_STAT_W1C) & ~`FPX_STAT_CMASK)
				| (WDATA[15:0] & `FPX_STAT_CMASK);
		end
		if (wr_imask)
		begin
			next_imask = WDATA[6:0] & `FPX_IMASK_WMASK;
		end
		if (wr_tag)
		begin
			for (int i = 0; i < `NUM_REGS; i++)
			begin
				next_empty[i] = WDATA[2*i+1 -: 2] == `TAG_EMPTY; // RULE2
			end
		end
		if (REG_WE)
		begin
			next_regs[REG_IDX] = REG_VALUE;
			next_empty[REG_IDX] = 1'b0;
		end
		if (do_init)
		begin
			next_ctrl = `FPX_CTRL_RST;
			next_stat = 16'h0000; // RULE17
			next_empty = '1;
		end
		// Hardware events win over a clear in the same cycle
		next_stat = next_stat | set_bits; // RULE18
		if (STACK_FAULT)
		begin
			next_stat[`SW_C1] = STACK_OVER; // RULE16
		end
	end

	// Read data and interrupt
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (RD)
		begin
			unique case (ADDR)
				`FPX_OFF_CTRL: next_rdata = {16'h0000, ctrl};
				`FPX_OFF_STAT:
				begin
					next_rdata = {16'h0000, stat};
					next_rdata[`SW_ES] = |(stat[5:0] & ~ctrl[5:0]);
				end
				`FPX_OFF_TAG: next_rdata = {16'h0000, tag_word}; // RULE4
				`FPX_OFF_IMASK: next_rdata = {25'h0000000, imask};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		next_irq = |(next_stat[6:0] & next_imask);
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			ctrl <= `FPX_CTRL_RST;
			stat <= 16'h0000; // RULE17
			imask <= 7'h00;
			empty <= '1;
			for (int i = 0; i < `NUM_REGS; i++)
			begin
				regs[i] <= '0;
			end
			RDATA <= 32'h0000_0000;
			IRQ <= 1'b0;
		end
		else
		begin
			ctrl <= next_ctrl;
			stat <= next_stat;
			imask <= next_imask;
			empty <= next_empty;
			for (int i = 0; i < `NUM_REGS; i++)
			begin
				regs[i] <= next_regs[i];
			end
			RDATA <= next_rdata;
			IRQ <= next_irq;
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			RESP_VALID <= 1'b0;
			RESP_INVALID <= 1'b0;
			RESP_NORMALIZE <= 1'b0;
			RESP_QUIET_NAN <= 1'b0;
			RESP_MAX_FINITE <= 1'b0;
			RESP_INFINITY <= 1'b0;
			RESP_ADJUST_EXP <= 1'b0;
			RESP_ROUND_PREC <= `PC_EXT;
		end
		else
		begin
			RESP_VALID <= next_resp_valid;
			RESP_INVALID <= next_resp_invalid;
			RESP_NORMALIZE <= next_resp_normalize;
			RESP_QUIET_NAN <= next_resp_quiet_nan;
			RESP_MAX_FINITE <= next_resp_max_finite;
			RESP_INFINITY <= next_resp_infinity;
			RESP_ADJUST_EXP <= next_resp_adjust_exp;
			RESP_ROUND_PREC <= next_resp_round_prec;
		end
	end
endmodule
`default_nettype wire

// ==== dv/fpx_unit_props.sv ====
// Purpose: Port checks of the exception unit
// Assumes: Ctrl 00, status 04, tag 08, command 10
// Notes: Bound below
`timescale 1ns/1ps
`default_nettype none
module fpx_props
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [4:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic IRQ,
	input wire logic REG_WE,
	input wire logic OP_VALID,
	input wire logic RES_VALID,
	input wire logic RES_OVERFLOW,
	input wire logic STACK_FAULT,
	input wire logic STACK_OVER,
	input wire logic RESP_VALID,
	input wire logic RESP_MAX_FINITE,
	input wire logic RESP_INFINITY
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	a_ic_kept: assert property (WR && ADDR == 5'h00 ##1 RD && ADDR == 5'h00
		|=> RDATA[12] == $past(WDATA[12], 2)) else $error("ic bit lost");
	a_tag_load: assert property (WR && ADDR == 5'h08 && WDATA[15:0] == 16'hffff && !REG_WE
		##1 RD && ADDR == 5'h08 && !REG_WE |=> RDATA == 32'hffff) else $error("tag load wrong");
	a_fault_flags: assert property (STACK_FAULT ##1 RD && ADDR == 5'h04
		|=> RDATA[0] && RDATA[6] && RDATA[9] == $past(STACK_OVER, 2)) else $error("fault flags wrong");
	a_init_cond: assert property (WR && ADDR == 5'h10 && WDATA[0] && !STACK_FAULT
		##1 RD && ADDR == 5'h04 && !STACK_FAULT |=> (RDATA & 32'h4700) == 0) else $error("cond kept");
	a_ovf_prec: assert property (RES_VALID && RES_OVERFLOW ##1 RD && ADDR == 5'h04
		|=> RDATA[3] && RDATA[5]) else $error("overflow flags wrong");
	a_flag_sticky: assert property (RD && ADDR == 5'h04 ##1 RD && ADDR == 5'h04
		|=> (RDATA & $past(RDATA) & 32'h7f) == ($past(RDATA) & 32'h7f)) else $error("flag lost");
	a_no_resp: assert property (!OP_VALID && !RES_VALID
		|=> !RESP_VALID && !RESP_MAX_FINITE && !RESP_INFINITY) else $error("stray response");
	a_resp_next: assert property (OP_VALID || RES_VALID |=> RESP_VALID) else $error("no response");
	c_fault: cover property (STACK_FAULT && STACK_OVER);
	c_ovf: cover property (RES_VALID && RES_OVERFLOW);
	c_irq: cover property ($rose(IRQ));
endmodule
bind fp_special_value_exception_unit fpx_props fpx_props_i
(
	.CLOCK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .REG_WE, .OP_VALID, .RES_VALID,
	.RES_OVERFLOW, .STACK_FAULT, .STACK_OVER, .RESP_VALID, .RESP_MAX_FINITE, .RESP_INFINITY
);
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the exception unit
// Assumes: Ctrl 00, status 04, tag 08, mask 0c, command 10
// Notes: Results checked from a queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock, rst, wr, rd, we, ov, rv, sf, so, rd_d, irq, rvalid;
	logic [4:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] idx, oreg;
	logic [4:0] rf;
	logic [1:0] prec;
	wire logic [7:0] rsp;
	logic [63:0] fr;
	logic [15:0] ot [11] = '{16'h05a0, 16'h0620, 16'h16a0, 16'h26a0, 16'h36a0, 16'h6500,
		16'h02a0, 16'h0440, 16'h4440, 16'h5440, 16'h0000};
	fpx_pkg::ext_t val;
	fpx_pkg::op_kind_e kind;
	logic [31:0] eq [$];
	logic [31:0] mq [$];
	int fail_count;
	int checks_done;
	fp_special_value_exception_unit fp_special_value_exception_unit_i
	(
		.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
		.REG_WE(we), .REG_IDX(idx), .REG_VALUE(val), .OP_VALID(ov), .OP_KIND(kind), .OP_REG(oreg),
		.RES_VALID(rv), .RES_OVERFLOW(rf[4]), .RES_TINY(rf[3]), .RES_LOSS(rf[2]), .RES_INEXACT(1'b0),
		.RES_STACK(rf[1]), .RES_PC_CTRL(rf[0]), .RES_PREC(prec), .STACK_FAULT(sf), .STACK_OVER(so),
		.RESP_VALID(rvalid), .RESP_INVALID(rsp[7]), .RESP_NORMALIZE(rsp[6]), .RESP_QUIET_NAN(rsp[5]),
		.RESP_MAX_FINITE(rsp[4]), .RESP_INFINITY(rsp[3]), .RESP_ADJUST_EXP(rsp[2]), .RESP_ROUND_PREC(rsp[1:0])
	);
	task print_verdict;
		if (eq.size() != 0)
		begin
			fail_count++;
			$display("Error %0t results missing", $time);
		end
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] got, exp, m);
		checks_done++;
		if ((got & m) !== (exp & m))
		begin
			fail_count++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input logic w, r, e, o, v, s, input logic [4:0] a, input logic [31:0] d);
		wr <= w;
		rd <= r;
		we <= e;
		ov <= o;
		rv <= v;
		sf <= s;
		addr <= a;
		wdata <= d;
		@(posedge clock);
	endtask
	task idle(input int n);
		repeat (n) cyc(0, 0, 0, 0, 0, 0, 0, 0);
	endtask
	task wrr(input logic [4:0] a, input logic [31:0] d);
		cyc(1, 0, 0, 0, 0, 0, a, d);
	endtask
	task rdr(input logic [4:0] a, input logic [31:0] e, m);
		eq.push_back(e);
		mq.push_back(m);
		cyc(0, 1, 0, 0, 0, 0, a, 0);
	endtask
	task ld(input logic [2:0] i, input fpx_pkg::ext_t v);
		idx <= i;
		val <= v;
		cyc(0, 0, 1, 0, 0, 0, 0, 0);
	endtask
	task op(input fpx_pkg::op_kind_e k, input logic [2:0] r, input logic [7:0] e, m);
		kind <= k;
		oreg <= r;
		eq.push_back({24'h0, e});
		mq.push_back({24'h0, m});
		cyc(0, 0, 0, 1, 0, 0, 0, 0);
	endtask
	task res(input logic [15:0] c, input logic [6:0] f, input logic [7:0] e, m);
		wrr(5'h00, {16'h0, c});
		{rf, prec} <= f;
		eq.push_back({24'h0, e});
		mq.push_back({24'h0, m});
		cyc(0, 0, 0, 0, 1, 0, 0, 0);
	endtask
	task flt(input logic o);
		so <= o;
		cyc(0, 0, 0, 0, 0, 1, 0, 0);
	endtask
	initial
	begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock)
		rd_d <= rd;
	always @(negedge clock)
		if (rd_d || rvalid)
		begin
			if (eq.size() == 0)
			begin
				fail_count++;
				$display("Error %0t unexpected result", $time);
			end
			else
				cmp(rd_d ? rdata : {24'h0, rsp}, eq.pop_front(), mq.pop_front());
		end
	initial
	begin
		repeat (5000) @(posedge clock);
		fail_count++;
		$display("Error %0t timeout", $time);
		print_verdict;
	end
	initial
	begin
		{rst, wr, rd, we, ov, rv, sf, so} = 8'h80;
		{addr, wdata, idx, oreg, rf, prec, val} = '0;
		kind = fpx_pkg::OPK_ARITH;
		fail_count = 0;
		checks_done = 0;
		void'($urandom(30));
		fr = {$urandom, $urandom};
		repeat (10) @(posedge clock);
		rst <= 0;
		idle(1);
		rdr(5'h00, 32'h037f, '1);
		rdr(5'h04, 0, '1);
		rdr(5'h08, 32'hffff, '1);
		rdr(5'h0c, 0, '1);
		rdr(5'h14, 0, '1);
		wrr(5'h00, '1);
		rdr(5'h00, 32'h1f3f, '1);
		wrr(5'h00, 32'h037f);
		ld(0, 80'h3fff8000000000000000);
		ld(1, 0);
		ld(2, 80'h40004000000000000000);
		ld(3, 80'h00008000000000000000);
		ld(4, {17'h0, fr[62:1], 1'b1});
		ld(5, {16'h7fff, 2'b10, fr[61:1], 1'b1});
		ld(6, {16'hffff, 2'b11, fr[61:0]});
		rdr(5'h08, 32'heaa4, '1);
		wrr(5'h08, 32'h5555);
		rdr(5'h08, 32'h6aa4, '1);
		wrr(5'h08, 32'h0c00);
		rdr(5'h08, 32'h6ea4, '1);
		foreach (ot[i])
			op(fpx_pkg::op_kind_e'(ot[i][14:12]), ot[i][10:8], ot[i][7:0], 8'he0);
		rdr(5'h04, 3, '1);
		rdr(5'h04, 3, '1);
		wrr(5'h0c, 2);
		idle(1);
		cmp({31'h0, irq}, 1, 1);
		wrr(5'h0c, 0);
		idle(1);
		cmp({31'h0, irq}, 0, 1);
		wrr(5'h0c, 2);
		wrr(5'h04, 32'h7f);
		idle(1);
		cmp({31'h0, irq}, 0, 1);
		wrr(5'h00, 32'h037d);
		op(fpx_pkg::OPK_ARITH, 4, 0, 8'he0);
		rdr(5'h04, 32'h82, '1);
		wrr(5'h04, 32'h7f);
		res(16'h0f7f, 7'h4f, 8'h10, 8'h18);
		res(16'h037f, 7'h4f, 8'h08, 8'h18);
		res(16'h0377, 7'h4f, 8'h03, 8'h1b);
		res(16'h0077, 7'h4f, 8'h00, 8'h1b);
		res(16'h0077, 7'h4a, 8'h02, 8'h1b);
		rdr(5'h04, 32'ha8, '1);
		wrr(5'h04, 32'h7f);
		res(16'h037f, 7'h20, 0, 0);
		rdr(5'h04, 0, '1);
		res(16'h037f, 7'h30, 0, 0);
		rdr(5'h04, 32'h30, '1);
		res(16'h036f, 7'h2f, 8'h07, 8'h07);
		res(16'h006f, 7'h2c, 8'h04, 8'h07);
		res(16'h006f, 7'h28, 8'h07, 8'h07);
		wrr(5'h04, 32'h7f);
		flt(1);
		rdr(5'h04, 32'h241, 32'h4767);
		flt(0);
		rdr(5'h04, 32'h41, 32'h4767);
		wrr(5'h04, {16'h0, fr[15:0] & 16'h4700});
		rdr(5'h04, {16'h0, fr[15:0]}, 32'h4700);
		wrr(5'h10, 1);
		rdr(5'h04, 0, '1);
		rdr(5'h00, 32'h037f, '1);
		rdr(5'h08, 32'hffff, '1);
		wrr(5'h08, 32'hffff);
		rdr(5'h08, 32'hffff, '1);
		wrr(5'h04, 32'h4700);
		rst <= 1;
		idle(2);
		rst <= 0;
		idle(1);
		rdr(5'h04, 0, '1);
		rdr(5'h00, 32'h037f, '1);
		idle(2);
		print_verdict;
	end
endmodule
`default_nettype wire
